//--- include/cdff_pkg.sv
// constants and variant list shared by the storage cell and its top
// assumes one clock; data, clear and preset arrive synchronous to it
// Contract
// - plain variant copies data to output each rising edge, holds between
// - enabled variant captures data on a rising edge only while enable is 1
// - open inputs read 0, except enable which reads 1 and nrst which has no default
// - sync-clear variant captures data at the edge only while clear is low
// - sync-clear variant clears output to 0 at the edge, over data
// - async-clear variant clears output at once, overriding all but the block reset
// - async-clear variant captures data at the edge while clear is low
// - sync-preset variant drives output to 1 at the edge, over data
// - sync-preset variant captures data at the edge only while preset is low
// - async-preset variant drives output to 1 at once, overriding all but the block reset
// - async-preset variant captures data at the edge while preset is low
`default_nettype none

package cdff_pkg;

  // one storage behaviour per instance
  typedef enum logic [2:0] {
    CDFF_PLAIN_FF        = 3'h0,
    CDFF_ENABLED_FF      = 3'h1,
    CDFF_SYNC_CLEAR_FF   = 3'h2,
    CDFF_ASYNC_CLEAR_FF  = 3'h3,
    CDFF_SYNC_PRESET_FF  = 3'h4,
    CDFF_ASYNC_PRESET_FF = 3'h5
  } cdff_variant_t;

  localparam logic CDFF_RESET_VAL = 1'h0;   // output after the block reset
  localparam logic CDFF_CLEAR_VAL = 1'h0;   // value forced by clear
  localparam logic CDFF_PRESET_VAL = 1'h1;  // value forced by preset
  localparam logic CDFF_OPEN_LOW = 1'h0;    // open data, clock, clear, preset
  localparam logic CDFF_OPEN_ENABLE = 1'h1; // open enable keeps the cell live
  localparam int CDFF_SYNC_STAGES = 2;      // reset release flops

endpackage

`default_nettype wire

//--- include/cdff_if.sv
// carrier between the cell control logic and the storage flop
// assumes both ends share clk and the synchronised reset
`default_nettype none

interface cdff_if (
  input wire logic clk
);
  logic rst_n;    // synchronised block reset, active low
  logic next_q;   // value to load at the next rising edge
  logic force_on; // asynchronous force, active high
  logic q;        // stored bit

  modport ctrl (
    input clk,
    input q,
    output rst_n,
    output next_q,
    output force_on
  );

  modport store (
    input clk,
    input rst_n,
    input next_q,
    input force_on,
    output q
  );
endinterface

`default_nettype wire

//--- logic/cdff_store.sv
// the single storage flop with an optional asynchronous force
// assumes force_on is tied low for variants without an asynchronous control
`default_nettype none

module cdff_store #(
  parameter logic FORCE_VAL = cdff_pkg::CDFF_CLEAR_VAL
) (
  cdff_if.store port_s
);

  // force acts without a clock edge and wins over the loaded value
  always_ff @(posedge port_s.clk or negedge port_s.rst_n or posedge port_s.force_on) begin
    if (!port_s.rst_n) begin
      port_s.q <= cdff_pkg::CDFF_RESET_VAL;
    end else if (port_s.force_on) begin
      port_s.q <= FORCE_VAL;
    end else begin
      port_s.q <= port_s.next_q;
    end
  end

endmodule

`default_nettype wire

//--- logic/cdff_cell.sv
// configurable single-bit storage cell, one variant per instance
// assumes data, enable, clear and preset are synchronous to clk unless the
// variant treats clear or preset as an asynchronous control
`default_nettype none

module cdff_cell #(
  parameter cdff_pkg::cdff_variant_t VARIANT = cdff_pkg::CDFF_PLAIN_FF
) (
  input wire logic clk = cdff_pkg::CDFF_OPEN_LOW,
  input wire logic nrst,
  input wire logic data = cdff_pkg::CDFF_OPEN_LOW,
  input wire logic enable = cdff_pkg::CDFF_OPEN_ENABLE,
  input wire logic clear = cdff_pkg::CDFF_OPEN_LOW,
  input wire logic preset = cdff_pkg::CDFF_OPEN_LOW,
  output var logic q
);

  localparam bit IS_ASYNC_PRESET = (VARIANT == cdff_pkg::CDFF_ASYNC_PRESET_FF);
  localparam bit IS_ASYNC_CLEAR = (VARIANT == cdff_pkg::CDFF_ASYNC_CLEAR_FF);

  // only six codes serve a variant; anything else is refused here
  if (VARIANT > cdff_pkg::CDFF_ASYNC_PRESET_FF) begin : g_bad_variant
    $error("cdff_cell: unsupported variant code");
  end

  // the release path below is built as two flops; a longer chain needs more stages here
  if (cdff_pkg::CDFF_SYNC_STAGES != 2) begin : g_bad_sync
    $error("cdff_cell: reset release expects two stages");
  end

  cdff_if bus (.clk(clk));

  logic rst_meta;
  logic rst_sync;
  logic next_rst_meta;
  logic next_rst_sync;
  logic next_q;
  logic force_on;

  // reset release through two flops; assertion stays asynchronous
  always_comb begin
    next_rst_meta = 1'h1;
    next_rst_sync = rst_meta;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'h0;
      rst_sync <= 1'h0;
    end else begin
      rst_meta <= next_rst_meta;
      rst_sync <= next_rst_sync;
    end
  end

  // next stored value; inputs a variant does not own are ignored
  always_comb begin
    next_q = data;
    unique case (VARIANT)
      cdff_pkg::CDFF_PLAIN_FF: begin
        next_q = data;
      end
      cdff_pkg::CDFF_ENABLED_FF: begin
        next_q = enable ? data : bus.q;
      end
      cdff_pkg::CDFF_SYNC_CLEAR_FF: begin
        next_q = clear ? cdff_pkg::CDFF_CLEAR_VAL : data;
      end
      cdff_pkg::CDFF_ASYNC_CLEAR_FF: begin
        next_q = data;
      end
      cdff_pkg::CDFF_SYNC_PRESET_FF: begin
        next_q = preset ? cdff_pkg::CDFF_PRESET_VAL : data;
      end
      cdff_pkg::CDFF_ASYNC_PRESET_FF: begin
        next_q = data;
      end
      default: begin
        next_q = data;
      end
    endcase
  end

  // asynchronous force path; a glitch on clear or preset reaches the flop,
  // so those pins must come from clean logic in the async variants
  always_comb begin
    force_on = 1'h0;
    if (IS_ASYNC_CLEAR) begin
      force_on = clear;
    end else if (IS_ASYNC_PRESET) begin
      force_on = preset;
    end
  end

  assign bus.rst_n = rst_sync;
  assign bus.next_q = next_q;
  assign bus.force_on = force_on;

  // one flop per instance, force value fixed by the variant
  cdff_store #(
    .FORCE_VAL(IS_ASYNC_PRESET ? cdff_pkg::CDFF_PRESET_VAL : cdff_pkg::CDFF_CLEAR_VAL)
  ) u_store (
    .port_s(bus.store)
  );

  // output straight from the storage flop
  assign q = bus.q;

  // checks, one group per variant
  if (VARIANT == cdff_pkg::CDFF_PLAIN_FF) begin : g_chk_plain
    a_plain_copy_data: assert property (
      @(posedge clk) disable iff (!rst_sync)
      rst_sync |=> q == $past(data)
    ) else $error("plain cell did not copy data");
    a_plain_ignore_ctrl: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && clear && preset && !enable) |=> q == $past(data)
    ) else $error("plain cell reacted to a control input");
  end

  if (VARIANT == cdff_pkg::CDFF_ENABLED_FF) begin : g_chk_enabled
    a_enabled_load: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && enable) |=> q == $past(data)
    ) else $error("enabled cell missed data");
    a_enabled_hold: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !enable && (data != q)) |=> $stable(q)
    ) else $error("disabled cell changed its output");
    a_enabled_hold_run: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !enable) [*3] |=> q == $past(q, 3)
    ) else $error("disabled cell drifted over several edges");
  end

  if (VARIANT == cdff_pkg::CDFF_SYNC_CLEAR_FF) begin : g_chk_sync_clear
    a_sclr_to_zero: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && clear) |=> q == cdff_pkg::CDFF_CLEAR_VAL
    ) else $error("sync clear did not clear at the edge");
    a_sclr_load: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !clear) |=> q == $past(data)
    ) else $error("sync clear cell missed data");
  end

  if (VARIANT == cdff_pkg::CDFF_ASYNC_CLEAR_FF) begin : g_chk_async_clear
    a_aclr_holds_zero: assert property (
      @(posedge clk) disable iff (!rst_sync)
      clear |-> q == cdff_pkg::CDFF_CLEAR_VAL
    ) else $error("async clear did not hold output low");
    a_aclr_load: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !clear) ##1 !clear |-> q == $past(data)
    ) else $error("async clear cell missed data");
  end

  if (VARIANT == cdff_pkg::CDFF_SYNC_PRESET_FF) begin : g_chk_sync_preset
    a_sset_to_one: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && preset) |=> q == cdff_pkg::CDFF_PRESET_VAL
    ) else $error("sync preset did not set at the edge");
    a_sset_load: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !preset) |=> q == $past(data)
    ) else $error("sync preset cell missed data");
  end

  if (VARIANT == cdff_pkg::CDFF_ASYNC_PRESET_FF) begin : g_chk_async_preset
    a_aset_holds_one: assert property (
      @(posedge clk) disable iff (!rst_sync)
      preset |-> q == cdff_pkg::CDFF_PRESET_VAL
    ) else $error("async preset did not hold output high");
    a_aset_load: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !preset) ##1 !preset |-> q == $past(data)
    ) else $error("async preset cell missed data");
  end

  // a plain cell owns no control pin, so each one alone must leave the load untouched;
  // the falling-edge check shows the output standing between rising edges
  if (VARIANT == cdff_pkg::CDFF_PLAIN_FF) begin : g_chk_plain_more
    a_plain_skip_clear: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && clear) |=> q == $past(data)
    ) else $error("plain cell reacted to clear");
    a_plain_skip_preset: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && preset) |=> q == $past(data)
    ) else $error("plain cell reacted to preset");
    a_plain_skip_enable: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !enable) |=> q == $past(data)
    ) else $error("plain cell reacted to enable");
    a_plain_mid_cycle: assert property (
      @(negedge clk) disable iff (!rst_sync)
      $past(rst_sync) |-> q == data
    ) else $error("plain cell output moved between edges");
  end

  // enabled cell ignores clear and preset; a low enable keeps the old bit
  if (VARIANT == cdff_pkg::CDFF_ENABLED_FF) begin : g_chk_enabled_more
    a_enabled_skip_clear: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && enable && clear) |=> q == $past(data)
    ) else $error("enabled cell reacted to clear");
    a_enabled_skip_preset: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && enable && preset) |=> q == $past(data)
    ) else $error("enabled cell reacted to preset");
    a_enabled_keep_any: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !enable) |=> q == $past(q)
    ) else $error("disabled cell lost its bit");
    a_enabled_mid_cycle: assert property (
      @(negedge clk) disable iff (!rst_sync)
      $past(rst_sync) |-> q == (enable ? data : $past(q))
    ) else $error("enabled cell output wrong between edges");
  end

  // sync clear: preset and enable are not its pins; clear acts only at an edge
  if (VARIANT == cdff_pkg::CDFF_SYNC_CLEAR_FF) begin : g_chk_sync_clear_more
    a_sclr_skip_preset: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !clear && preset) |=> q == $past(data)
    ) else $error("sync clear cell reacted to preset");
    a_sclr_skip_enable: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !clear && !enable) |=> q == $past(data)
    ) else $error("sync clear cell reacted to enable");
    a_sclr_over_data: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && clear && data) |=> q == cdff_pkg::CDFF_CLEAR_VAL
    ) else $error("sync clear lost against a high data bit");
    a_sclr_edge_only: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && $past(rst_sync) && $rose(clear)) |-> q == $past(data)
    ) else $error("sync clear acted before the edge");
  end

  // async clear: other pins ignored; an edge while clear is high loads nothing
  if (VARIANT == cdff_pkg::CDFF_ASYNC_CLEAR_FF) begin : g_chk_async_clear_more
    a_aclr_skip_preset: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !clear && preset) ##1 !clear |-> q == $past(data)
    ) else $error("async clear cell reacted to preset");
    a_aclr_skip_enable: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !clear && !enable) ##1 !clear |-> q == $past(data)
    ) else $error("async clear cell reacted to enable");
    a_aclr_edge_blocked: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && clear) ##1 !clear |-> q == cdff_pkg::CDFF_CLEAR_VAL
    ) else $error("async clear cell loaded data while cleared");
    a_aclr_mid_cycle: assert property (
      @(negedge clk) disable iff (!rst_sync)
      clear |-> q == cdff_pkg::CDFF_CLEAR_VAL
    ) else $error("async clear did not act between edges");
  end

  // sync preset: clear and enable are not its pins; preset acts only at an edge
  if (VARIANT == cdff_pkg::CDFF_SYNC_PRESET_FF) begin : g_chk_sync_preset_more
    a_sset_skip_clear: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !preset && clear) |=> q == $past(data)
    ) else $error("sync preset cell reacted to clear");
    a_sset_skip_enable: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !preset && !enable) |=> q == $past(data)
    ) else $error("sync preset cell reacted to enable");
    a_sset_over_data: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && preset && !data) |=> q == cdff_pkg::CDFF_PRESET_VAL
    ) else $error("sync preset lost against a low data bit");
    a_sset_edge_only: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && $past(rst_sync) && $rose(preset)) |-> q == $past(data)
    ) else $error("sync preset acted before the edge");
  end

  // async preset: other pins ignored; an edge while preset is high loads nothing
  if (VARIANT == cdff_pkg::CDFF_ASYNC_PRESET_FF) begin : g_chk_async_preset_more
    a_aset_skip_clear: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !preset && clear) ##1 !preset |-> q == $past(data)
    ) else $error("async preset cell reacted to clear");
    a_aset_skip_enable: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && !preset && !enable) ##1 !preset |-> q == $past(data)
    ) else $error("async preset cell reacted to enable");
    a_aset_edge_blocked: assert property (
      @(posedge clk) disable iff (!rst_sync)
      (rst_sync && preset) ##1 !preset |-> q == cdff_pkg::CDFF_PRESET_VAL
    ) else $error("async preset cell loaded data while set");
    a_aset_mid_cycle: assert property (
      @(negedge clk) disable iff (!rst_sync)
      preset |-> q == cdff_pkg::CDFF_PRESET_VAL
    ) else $error("async preset did not act between edges");
  end

endmodule

`default_nettype wire

//--- verif/cdff_cell_bench.sv
// bench for the storage cell: all six variants side by side plus an open enable
// assumes q loads at the 3rd rising edge after nrst rises and holds 0 before
`default_nettype none

module cdff_cell_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic nrst;
  logic data;
  logic enable;
  logic clear;
  logic preset;
  wire logic [6:0] qv;
  int m[7];
  int rel_cnt;
  int mismatches;
  int n_tests;

  // one instance per variant code, all sharing the same stimulus
  for (genvar g = 0; g < 6; g++) begin : g_cell
    cdff_cell #(.VARIANT(cdff_pkg::cdff_variant_t'(g))) i_cdff_cell (
      .clk(clk), .nrst(nrst), .data(data), .enable(enable), .clear(clear), .preset(preset), .q(qv[g]));
  end

  // enable omitted on purpose: the cell must act as if always enabled
  cdff_cell #(.VARIANT(cdff_pkg::CDFF_ENABLED_FF)) i_cdff_cell (
    .clk(clk), .nrst(nrst), .data(data), .clear(clear), .preset(preset), .q(qv[6]));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // reference model; two edges of reset release pass before any load
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt <= 0;
      for (int k = 0; k < 7; k++) m[k] <= 0;
    end else if (rel_cnt < cdff_pkg::CDFF_SYNC_STAGES) begin
      rel_cnt <= rel_cnt + 1;
    end else begin
      m[0] <= data;
      if (enable) m[1] <= data;
      m[2] <= clear ? 0 : int'(data);
      m[3] <= clear ? 0 : int'(data);
      m[4] <= preset ? 1 : int'(data);
      m[5] <= preset ? 1 : int'(data);
      m[6] <= data;
    end
  end

  // async variants follow their force pin at once, but only once released
  function automatic logic exp_q(int k);
    logic r;
    r = (nrst === 1'b1) && (rel_cnt == cdff_pkg::CDFF_SYNC_STAGES);
    if (k == 3 && r && clear === 1'b1) return 1'b0;
    if (k == 5 && r && preset === 1'b1) return 1'b1;
    return 1'(m[k]);
  endfunction

  task automatic chk(string name, logic e, logic g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic check_all();
    chk("plain_ff", exp_q(0), qv[0]);
    chk("enabled_ff", exp_q(1), qv[1]);
    chk("sync_clear_ff", exp_q(2), qv[2]);
    chk("async_clear_ff", exp_q(3), qv[3]);
    chk("sync_preset_ff", exp_q(4), qv[4]);
    chk("async_preset_ff", exp_q(5), qv[5]);
    chk("open_enable_ff", exp_q(6), qv[6]);
  endtask

  // clear and preset stay low until release so the force timing is unambiguous
  task automatic drive(logic live);
    data = 1'($urandom);
    enable = 1'($urandom);
    clear = live && ($urandom_range(3) == 0);
    preset = live && ($urandom_range(3) == 0);
  endtask

  task automatic results();
    if (mismatches == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // random traffic with a short reset in mid-run; checks before and after each drive
  initial begin
    nrst = 1'b0;
    data = 1'b0;
    enable = 1'b1;
    clear = 1'b0;
    preset = 1'b0;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(32'h1b040854));
    repeat (5) @(posedge clk);
    @(negedge clk);
    check_all();
    nrst = 1'b1;
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      check_all();
      if (i == 200) nrst = 1'b0;
      else if (i == 202) nrst = 1'b1;
      drive(nrst === 1'b1 && rel_cnt == cdff_pkg::CDFF_SYNC_STAGES);
      #1;
      check_all();
    end
    results();
  end
endmodule

`default_nettype wire
